//--- src/pccs_sideband.sv
/*
 * Configuration control sideband of a PCI Express core: hot reset,
 * configuration enable and retry completions, per-function output
 * handshake, device serial number capture, downstream bus id.
 * Assumes user logic on i_clock; registers on Avalon-MM with waitrequest.
 */
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pccs_sideband (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Sideband
    input  wire logic        i_hot_reset_req,
    input  wire logic        i_cfg_space_enable,
    input  wire logic [2:0]  i_func_number,
    input  wire logic        i_func_out_req,
    input  wire logic [63:0] i_serial_number,
    input  wire logic        i_cfg_input_update,
    input  wire logic [7:0]  i_downstream_bus_id_in,
    input  wire logic        i_cfg_req,
    input  wire logic        i_gen_tlp,
    output logic             o_hot_reset_out,
    output logic             o_ltssm_hot_reset,
    output logic             o_func_update_done,
    output logic [15:0]      o_func_status,
    output logic             o_func_is_virtual,
    output logic [31:0]      o_dsn_lower,
    output logic [31:0]      o_dsn_upper,
    output logic [7:0]       o_gen_req_bus,
    output logic             o_gen_valid,
    output logic             o_cpl_valid,
    output logic             o_cpl_crs
);

    // ==========================================================
    // Declarations
    // ==========================================================
    typedef enum logic [1:0] {PCCS_IDLE, PCCS_FETCH, PCCS_DONE} pccs_req_state_t;

    pccs_req_state_t     req_state_reg;
    logic [1:0]          req_wait_reg;
    logic [2:0]          req_func_reg;
    logic [31:0]         ctrl_reg;
    logic [2:0]          sel_func_reg;
    logic [15:0]         func_wdata_reg;
    logic                func_we_reg;
    logic                access_reg;
    logic [15:0]         rd_status;
    pccs_pkg::pccs_cpl_t cpl;
    logic [7:0]          crs_count;
    logic                root_port;
    logic                downstream;
    logic [2:0]          rd_func;

    assign root_port  = ctrl_reg[pccs_pkg::CTRL_ROOT_PORT];
    assign downstream = ctrl_reg[pccs_pkg::CTRL_DOWNSTREAM];
    assign rd_func    = (req_state_reg == PCCS_IDLE) ? i_func_number : req_func_reg;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_val;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // ==========================================================
    // Sub-blocks
    // ==========================================================
    pccs_func_store #(
        .WIDTH (pccs_pkg::STATUS_WIDTH),
        .DEPTH (pccs_pkg::FUNC_COUNT)
    ) u_store (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_wr_en   (func_we_reg),
        .i_wr_func (sel_func_reg),
        .i_wr_data (func_wdata_reg),
        .i_rd_func (rd_func),
        .o_rd_data (rd_status)
    );

    pccs_cfg_responder u_resp (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_root_port  (root_port),
        .i_cfg_enable (i_cfg_space_enable),
        .i_cfg_req    (i_cfg_req),
        .o_cpl        (cpl),
        .o_crs_count  (crs_count)
    );

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_cpl_valid <= 1'b0;
            o_cpl_crs   <= 1'b0;
        end
        else
        begin
            o_cpl_valid <= (cpl != pccs_pkg::PCCS_CPL_NONE);
            o_cpl_crs   <= (cpl == pccs_pkg::PCCS_CPL_CRS);
        end
    end

    // ==========================================================
    // Hot reset
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_ltssm_hot_reset <= 1'b0;
            o_hot_reset_out   <= 1'b0;
        end
        else
        begin
            o_ltssm_hot_reset <= root_port && i_hot_reset_req;
            o_hot_reset_out   <= !root_port && ctrl_reg[pccs_pkg::CTRL_HOT_RST_EP];
        end
    end

    // ==========================================================
    // Per-function request handshake
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            req_state_reg      <= PCCS_IDLE;
            req_wait_reg       <= 2'h0;
            req_func_reg       <= 3'h0;
            o_func_update_done <= 1'b0;
            o_func_status      <= 16'h0000;
            o_func_is_virtual  <= 1'b0;
        end
        else
        begin
            o_func_update_done <= 1'b0;
            unique case (req_state_reg)
                PCCS_IDLE:
                begin
                    if (i_func_out_req)
                    begin
                        req_func_reg  <= i_func_number;
                        req_wait_reg  <= pccs_pkg::UPDATE_LAT;
                        req_state_reg <= PCCS_FETCH;
                    end
                end
                PCCS_FETCH:
                begin
                    if (req_wait_reg == 2'h1)
                    begin
                        o_func_status     <= rd_status;
                        o_func_is_virtual <= (req_func_reg >= pccs_pkg::NUM_PF);
                        req_state_reg     <= PCCS_DONE;
                    end
                    req_wait_reg <= req_wait_reg - 2'h1;
                end
                PCCS_DONE:
                begin
                    o_func_update_done <= 1'b1;
                    req_state_reg      <= PCCS_IDLE;
                end
                default:
                begin
                    req_state_reg <= PCCS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Serial number capture
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_dsn_lower <= 32'h0000_0000;
            o_dsn_upper <= 32'h0000_0000;
        end
        else if (i_cfg_input_update)
        begin
            o_dsn_lower <= i_serial_number[31:0];
            o_dsn_upper <= i_serial_number[63:32];
        end
    end

    // ==========================================================
    // Internally generated requester bus
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_gen_req_bus <= 8'h00;
            o_gen_valid   <= 1'b0;
        end
        else
        begin
            o_gen_valid <= i_gen_tlp;
            if (i_gen_tlp && downstream)
            begin
                o_gen_req_bus <= i_downstream_bus_id_in;
            end
            else if (i_gen_tlp)
            begin
                o_gen_req_bus <= 8'h00;
            end
        end
    end

    // ==========================================================
    // Avalon-MM slave
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            access_reg        <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
            ctrl_reg          <= pccs_pkg::CTRL_RESET;
            sel_func_reg      <= 3'h0;
            func_wdata_reg    <= 16'h0000;
            func_we_reg       <= 1'b0;
        end
        else
        begin
            func_we_reg       <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            access_reg        <= 1'b0;
            if ((i_avs_read || i_avs_write) && !access_reg)
            begin
                access_reg        <= 1'b1;
                o_avs_waitrequest <= 1'b0;
                if (i_avs_write)
                begin
                    unique case (i_avs_address)
                        pccs_pkg::REG_CTRL:
                            ctrl_reg <= merge_bytes(ctrl_reg, i_avs_writedata, i_avs_byteenable);
                        pccs_pkg::REG_FUNC_SEL:
                            sel_func_reg <= i_avs_writedata[2:0];
                        pccs_pkg::REG_FUNC_DATA:
                        begin
                            func_wdata_reg <= i_avs_writedata[15:0];
                            func_we_reg    <= 1'b1;
                        end
                        default:
                        begin
                        end
                    endcase
                end
                else
                begin
                    unique case (i_avs_address)
                        pccs_pkg::REG_CTRL:
                            o_avs_readdata <= ctrl_reg;
                        pccs_pkg::REG_STATUS:
                            o_avs_readdata <= {16'h0000, crs_count, 4'h0,
                                               req_state_reg != PCCS_IDLE,
                                               i_cfg_space_enable,
                                               o_hot_reset_out,
                                               o_ltssm_hot_reset};
                        pccs_pkg::REG_DSN_LO:
                            o_avs_readdata <= o_dsn_lower;
                        pccs_pkg::REG_DSN_HI:
                            o_avs_readdata <= o_dsn_upper;
                        pccs_pkg::REG_FUNC_SEL:
                            o_avs_readdata <= {29'h0, sel_func_reg};
                        pccs_pkg::REG_FUNC_DATA:
                            o_avs_readdata <= {16'h0000, o_func_status};
                        pccs_pkg::REG_BUS_ID:
                            o_avs_readdata <= {24'h0, o_gen_req_bus};
                        default:
                            o_avs_readdata <= pccs_pkg::UNMAPPED_DATA;
                    endcase
                end
            end
        end
    end

endmodule : pccs_sideband

//--- include/pccs_pkg.sv
/*
 * Shared constants for the configuration control sideband block:
 * register offsets, field positions, reset values, function encoding.
 * Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
 */
package pccs_pkg;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_DSN_LO     = 8'h08;
    localparam logic [7:0] REG_DSN_HI     = 8'h0c;
    localparam logic [7:0] REG_FUNC_SEL   = 8'h10;
    localparam logic [7:0] REG_FUNC_DATA  = 8'h14;
    localparam logic [7:0] REG_BUS_ID     = 8'h18;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTRL_ROOT_PORT   = 0;
    localparam int CTRL_DOWNSTREAM  = 1;
    localparam int CTRL_HOT_RST_EP  = 2;
    localparam int ST_HOT_RST_LTSSM = 0;
    localparam int ST_HOT_RST_OUT   = 1;
    localparam int ST_CFG_ENABLED   = 2;
    localparam int ST_REQ_BUSY      = 3;
    localparam int ST_CRS_COUNT_LSB = 8;

    // ==========================================================
    // Reset values and encodings
    // ==========================================================
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'hdead_beef;
    localparam logic [2:0]  NUM_PF        = 3'h2;
    localparam int          FUNC_COUNT    = 8;
    localparam int          STATUS_WIDTH  = 16;
    localparam int          BUS_ID_WIDTH  = 8;
    localparam int          DSN_WIDTH     = 64;
    localparam logic [1:0]  UPDATE_LAT    = 2'h2;

    typedef enum logic [1:0]
    {
        PCCS_CPL_NONE,
        PCCS_CPL_SUCCESS,
        PCCS_CPL_CRS
    } pccs_cpl_t;

endpackage : pccs_pkg

//--- src/pccs_func_store.sv
/*
 * Per-function status store: one status word for each of the eight
 * functions (two physical, six virtual), with a selectable read port.
 * Assumes function index already validated to 3 bits.
 */
`timescale 1ns/1ps
module pccs_func_store #(
    parameter int WIDTH = pccs_pkg::STATUS_WIDTH,
    parameter int DEPTH = pccs_pkg::FUNC_COUNT
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_func,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_func,
    output logic      [WIDTH-1:0]         o_rd_data
);

    logic [WIDTH-1:0] store_reg [DEPTH];

    // Elaboration-time size check
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad_size
        $error("pccs_func_store: bad size");
    end

    // ==========================================================
    // Storage and read port
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < DEPTH; k++)
            begin
                store_reg[k] <= '0;
            end
        end
        else if (i_wr_en)
        begin
            store_reg[i_wr_func] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_rd_data <= '0;
        end
        else
        begin
            o_rd_data <= store_reg[i_rd_func];
        end
    end

endmodule : pccs_func_store

//--- src/pccs_cfg_responder.sv
/*
 * Configuration request responder: decides the completion status for
 * each incoming configuration request and counts retry answers.
 * Assumes requests arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
module pccs_cfg_responder (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic             i_root_port,
    input  wire logic             i_cfg_enable,
    input  wire logic             i_cfg_req,
    output pccs_pkg::pccs_cpl_t   o_cpl,
    output logic      [7:0]       o_crs_count
);

    // ==========================================================
    // Completion choice
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_cpl <= pccs_pkg::PCCS_CPL_NONE;
        end
        else if (!i_cfg_req)
        begin
            o_cpl <= pccs_pkg::PCCS_CPL_NONE;
        end
        else if (i_root_port)
        begin
            o_cpl <= pccs_pkg::PCCS_CPL_SUCCESS;
        end
        else if (!i_cfg_enable)
        begin
            o_cpl <= pccs_pkg::PCCS_CPL_CRS;
        end
        else
        begin
            o_cpl <= pccs_pkg::PCCS_CPL_SUCCESS;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_crs_count <= 8'h00;
        end
        else if (i_cfg_req && !i_root_port && !i_cfg_enable && o_crs_count != 8'hff)
        begin
            o_crs_count <= o_crs_count + 8'h01;
        end
    end

endmodule : pccs_cfg_responder

//--- verification/pccs_sideband_monitor.sv
/*
 * Checker for the configuration control sideband ports.
 * Assumes a bind to pccs_sideband; sees only its ports.
 */
`timescale 1ns/1ps
module pccs_sideband_monitor (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_hot_reset_req,
    input wire logic        i_cfg_space_enable,
    input wire logic [2:0]  i_func_number,
    input wire logic        i_func_out_req,
    input wire logic [63:0] i_serial_number,
    input wire logic        i_cfg_input_update,
    input wire logic [7:0]  i_downstream_bus_id_in,
    input wire logic        i_cfg_req,
    input wire logic        i_gen_tlp,
    input wire logic        o_ltssm_hot_reset,
    input wire logic        o_func_update_done,
    input wire logic        o_func_is_virtual,
    input wire logic [31:0] o_dsn_lower,
    input wire logic [31:0] o_dsn_upper,
    input wire logic [7:0]  o_gen_req_bus,
    input wire logic        o_gen_valid,
    input wire logic        o_cpl_valid,
    input wire logic        o_cpl_crs
);
    logic [63:0] serial_d;

    default clocking mon_cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Helpers and sequences
    // ==========================================================
    always_ff @(posedge i_clock)
        serial_d <= i_serial_number;

    sequence s_cpl_answer;
        ##2 o_cpl_valid;
    endsequence

    sequence s_done_pulse;
        o_func_update_done ##1 !o_func_update_done;
    endsequence

    // ==========================================================
    // Assertions
    // ==========================================================
    a_ltssm_from_req: assert property (
        o_ltssm_hot_reset |-> $past(i_hot_reset_req)) else $error("hot reset without request");
    a_cfg_answered: assert property (
        i_cfg_req |-> s_cpl_answer) else $error("config request not answered");
    a_crs_when_off: assert property (
        o_cpl_valid && o_cpl_crs |-> !$past(i_cfg_space_enable, 2)) else $error("retry while on");
    a_done_one_cycle: assert property (
        o_func_update_done |-> s_done_pulse) else $error("done pulse too long");
    a_done_after_req: assert property (
        o_func_update_done |-> $past(i_func_out_req, 4)) else $error("done without request");
    a_func_kind_map: assert property (
        o_func_update_done |-> o_func_is_virtual == ($past(i_func_number, 4) >= 3'h2))
        else $error("wrong function kind");
    a_serial_lower: assert property (
        $past(i_cfg_input_update) |-> o_dsn_lower == serial_d[31:0]) else $error("serial low");
    a_serial_upper: assert property (
        $past(i_cfg_input_update) |-> o_dsn_upper == serial_d[63:32]) else $error("serial high");
    a_gen_bus_src: assert property (
        o_gen_valid |-> o_gen_req_bus == $past(i_downstream_bus_id_in) || o_gen_req_bus == 8'h00)
        else $error("generated bus wrong");
    a_gen_timing: assert property (
        i_gen_tlp |=> o_gen_valid) else $error("generated packet late");
endmodule : pccs_sideband_monitor

//--- verification/pccs_user_model.sv
/*
 * User logic model issuing per-function output requests.
 * Assumes i_go pulses one cycle while o_busy is low.
 */
`timescale 1ns/1ps
module pccs_user_model (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire logic [2:0] i_func,
    input  wire logic       i_slow,
    input  wire logic       i_done,
    output logic            o_req,
    output logic [2:0]      o_num,
    output logic            o_busy
);
    logic [2:0] delay_cnt;
    logic       sent;

    always @(posedge i_clock)
    begin
        o_req <= 1'b0;
        if (i_rst)
        begin
            o_busy <= 1'b0;
            sent   <= 1'b0;
            o_num  <= 3'h0;
        end
        else if (i_go && !o_busy)
        begin
            o_busy    <= 1'b1;
            o_num     <= ~i_func;
            delay_cnt <= i_slow ? 3'($urandom_range(4, 1)) : 3'h0;
        end
        else if (o_busy && !sent && delay_cnt != 3'h0)
            delay_cnt <= delay_cnt - 3'h1;
        else if (o_busy && !sent)
        begin
            o_req <= 1'b1;
            o_num <= ~o_num;
            sent  <= 1'b1;
        end
        else if (sent && i_done)
        begin
            o_busy <= 1'b0;
            sent   <= 1'b0;
            o_num  <= ~o_num;
        end
    end
endmodule : pccs_user_model

//--- verification/pccs_sideband_tb.sv
/*
 * Self-checking bench for the configuration control sideband.
 * Assumes the monitor and user model files are compiled first.
 */
`timescale 1ns/1ps
module pccs_sideband_tb;
    logic clk, rst, av_rd, av_wr, hot_req, cfg_en, fn_req, upd, cfg_req, gen_tlp, av_wait;
    logic hot_out, ltssm, fn_done, fn_virt, gen_valid, cpl_valid, cpl_crs, go, slow, busy;
    logic [7:0] av_addr, bus_id, gen_bus, b;
    logic [31:0] av_wdata, av_rdata, dlo, dhi, q;
    logic [2:0] fn_num, go_func;
    logic [15:0] fn_status;
    logic [15:0] st[8];
    logic [63:0] serial, sv;
    logic cpl_q[$];
    logic [16:0] fn_q[$];
    logic [7:0] gen_q[$];
    int err_count, total_checks, n;

    pccs_sideband i_pccs_sideband (.i_clock(clk), .i_rst(rst), .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
        .i_hot_reset_req(hot_req), .i_cfg_space_enable(cfg_en), .i_func_number(fn_num),
        .i_func_out_req(fn_req), .i_serial_number(serial), .i_cfg_input_update(upd),
        .i_downstream_bus_id_in(bus_id), .i_cfg_req(cfg_req), .i_gen_tlp(gen_tlp),
        .o_hot_reset_out(hot_out), .o_ltssm_hot_reset(ltssm), .o_func_update_done(fn_done),
        .o_func_status(fn_status), .o_func_is_virtual(fn_virt), .o_dsn_lower(dlo),
        .o_dsn_upper(dhi), .o_gen_req_bus(gen_bus), .o_gen_valid(gen_valid),
        .o_cpl_valid(cpl_valid), .o_cpl_crs(cpl_crs));
    pccs_user_model i_pccs_user_model (.i_clock(clk), .i_rst(rst), .i_go(go),
        .i_func(go_func), .i_slow(slow), .i_done(fn_done), .o_req(fn_req), .o_num(fn_num),
        .o_busy(busy));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic av_access(input logic rd, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        av_addr  <= a;
        av_wdata <= d;
        av_rd    <= rd;
        av_wr    <= !rd;
        @(posedge clk);
        while (av_wait !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        q = av_rdata;
        check("bus answer", 0, n >= 50);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk);
    endtask : av_access

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // ==========================================================
    // Clock, watchdog, result watcher
    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end

    always @(posedge clk)
    begin
        if (!rst && cpl_valid === 1'b1)
            check("retry completion", cpl_q.pop_front(), cpl_crs);
        if (!rst && fn_done === 1'b1)
            check("function output", fn_q.pop_front(), {fn_virt, fn_status});
        if (!rst && gen_valid === 1'b1)
            check("generated bus", gen_q.pop_front(), gen_bus);
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        {av_rd, av_wr, hot_req, cfg_en, upd, cfg_req, gen_tlp, go, slow} = '0;
        {av_addr, bus_id, av_wdata, go_func, serial} = '0;
        rst = 1'b1;
        void'($urandom(96691));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        check("reset wait", 1, av_wait);
        av_access(1'b1, pccs_pkg::REG_CTRL, 32'h0);
        check("ctrl reset", pccs_pkg::CTRL_RESET, q);
        av_access(1'b1, 8'h40, 32'h0);
        check("unmapped read", pccs_pkg::UNMAPPED_DATA, q);
        av_access(1'b0, pccs_pkg::REG_CTRL, 32'h1);
        hot_req <= 1'b1;
        repeat (3) @(posedge clk);
        check("root hot reset", 1, ltssm);
        check("root hot out", 0, hot_out);
        av_access(1'b0, pccs_pkg::REG_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        check("endpoint hot out", 1, hot_out);
        check("endpoint ltssm", 0, ltssm);
        hot_req <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            av_access(1'b0, pccs_pkg::REG_CTRL, {31'h0, i[1]});
            cfg_en  <= i[0];
            cfg_req <= 1'b1;
            cpl_q.push_back(!i[1] && !i[0]);
            cpl_q.push_back(!i[1] && !i[0]);
            repeat (2) @(posedge clk);
            cfg_req <= 1'b0;
            repeat (4) @(posedge clk);
        end
        for (int f = 0; f < 8; f++)
        begin
            st[f] = 16'($urandom);
            av_access(1'b0, pccs_pkg::REG_FUNC_SEL, 32'(f));
            av_access(1'b0, pccs_pkg::REG_FUNC_DATA, {16'h0, st[f]});
        end
        for (int f = 0; f < 8; f++)
        begin
            go_func <= 3'(f) ^ 3'h5;
            slow    <= f[0];
            fn_q.push_back({(3'(f) ^ 3'h5) >= 3'h2, st[3'(f) ^ 3'h5]});
            go      <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            n = 0;
            @(posedge clk);
            while (busy === 1'b1 && n < 100)
            begin
                @(posedge clk);
                n++;
            end
            check("request done", 0, n >= 100);
        end
        for (int i = 0; i < 2; i++)
        begin
            sv = {$urandom, $urandom};
            serial <= sv;
            @(posedge clk);
            upd <= 1'b1;
            @(posedge clk);
            upd <= 1'b0;
            @(posedge clk);
            check("serial lower", sv[31:0], dlo);
            check("serial upper", sv[63:32], dhi);
        end
        serial <= ~sv;
        repeat (3) @(posedge clk);
        check("serial held", sv[31:0], dlo);
        for (int i = 0; i < 2; i++)
        begin
            av_access(1'b0, pccs_pkg::REG_CTRL, {30'h0, i[0], 1'b0});
            b = 8'($urandom);
            bus_id  <= b;
            gen_tlp <= 1'b1;
            gen_q.push_back(i[0] ? b : 8'h00);
            @(posedge clk);
            gen_tlp <= 1'b0;
            repeat (3) @(posedge clk);
        end
        check("results drained", 0, cpl_q.size() + fn_q.size() + gen_q.size());
        finish_test();
    end
endmodule : pccs_sideband_tb

bind pccs_sideband pccs_sideband_monitor i_pccs_sideband_monitor (.i_clock(i_clock),
    .i_rst(i_rst), .i_hot_reset_req(i_hot_reset_req), .i_cfg_space_enable(i_cfg_space_enable),
    .i_func_number(i_func_number), .i_func_out_req(i_func_out_req),
    .i_serial_number(i_serial_number), .i_cfg_input_update(i_cfg_input_update),
    .i_downstream_bus_id_in(i_downstream_bus_id_in), .i_cfg_req(i_cfg_req),
    .i_gen_tlp(i_gen_tlp), .o_ltssm_hot_reset(o_ltssm_hot_reset),
    .o_func_update_done(o_func_update_done), .o_func_is_virtual(o_func_is_virtual),
    .o_dsn_lower(o_dsn_lower), .o_dsn_upper(o_dsn_upper), .o_gen_req_bus(o_gen_req_bus),
    .o_gen_valid(o_gen_valid), .o_cpl_valid(o_cpl_valid), .o_cpl_crs(o_cpl_crs));
